// [bench/tb_top.sv]
`timescale 1ns/100ps
module tb_top;
  import wgen_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic clr = 1'b0;
  logic [15:0] paddr = 16'h0000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, hs_n, lp_n, q, n0;
  logic [11:0] hs_dac_code, lp_dac_code, last, lo, hi;
  logic pready, pslverr, hs_dac_load, lp_dac_load, e;
  int err_total = 0;
  int cmp_count = 0;
  always #2.5 pclk = ~pclk;
  wgen_top i_wgen_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .hs_dac_code(hs_dac_code), .hs_dac_load(hs_dac_load),
    .lp_dac_code(lp_dac_code), .lp_dac_load(lp_dac_load));
  wgen_dac_model i_wgen_dac_model (.pclk(pclk), .presetn(presetn), .clr(clr),
    .hs_code(hs_dac_code), .hs_load(hs_dac_load), .lp_code(lp_dac_code),
    .lp_load(lp_dac_load), .hs_n(hs_n), .lp_n(lp_n), .last(last), .lo(lo), .hi(hi));
  // ****************
  // shared tasks
  // ****************
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task apb(input logic w, input logic [15:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task wr(input logic [15:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task rdc(input string what, input logic [15:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(what, exp, q);
    chk("slave error", 32'h0, {31'h0, e});
  endtask : rdc
  task wait_n(input int n);
    repeat (n) @(posedge pclk);
  endtask : wait_n
  task print_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : print_verdict
  // ****************
  // watchdog: tests need about 15k cycles
  // ****************
  initial begin
    #250000;
    err_total++;
    print_verdict();
  end
  // ****************
  // tests
  // ****************
  initial begin
    wait_n(10);
    presetn <= 1'b1;
    rdc("wave_config reset", OFS_WAVE_CFG, 32'h30);
    for (int i = 0; i < 10; i++) begin
      rdc("waveform reg reset", OFS_LEVEL_ONE + 16'(4 * i), 32'h0);
    end
    apb(1'b0, 16'h2100, 32'hFFFF_FFFF);
    chk("unmapped error", 32'h1, {31'h0, e});
    // direct codes, then gain on and off
    wr(OFS_FAST_CODE, 32'h123);
    wait_n(4);
    chk("direct code", 32'h123, {20'h0, last});
    chk("fast loads", 32'h1, hs_n);
    wr(OFS_GAIN_CORR, 32'h1000);
    wr(OFS_FAST_CODE, 32'hC00);
    wait_n(4);
    chk("half gain code", 32'hA00, {20'h0, last});
    wr(OFS_OFFSET_CORR, 32'h10);
    wr(OFS_FAST_CODE, 32'hC00);
    wait_n(4);
    chk("gain offset code", 32'hA10, {20'h0, last});
    // both corrections off: the raw code must pass untouched
    wr(OFS_WAVE_CFG, 32'h00);
    wr(OFS_FAST_CODE, 32'hC00);
    wait_n(4);
    chk("gain bypass code", 32'hC00, {20'h0, last});
    wr(OFS_LP_CTRL, 32'h40);
    wr(OFS_FAST_CODE, 32'h321);
    wait_n(4);
    chk("low power loads", 32'h1, lp_n);
    chk("low power code", 32'h321, {20'h0, last});
    chk("fast loads after lp", 32'h4, hs_n);
    wr(OFS_LP_CTRL, 32'h0);
    wr(OFS_GAIN_CORR, 32'h2000);
    wr(OFS_OFFSET_CORR, 32'h0);
    // square wave from zero slopes
    wr(OFS_LEVEL_ONE, 32'h100);
    wr(OFS_LEVEL_TWO, 32'h700);
    wr(OFS_DELAY_ONE, 32'h1);
    wr(OFS_DELAY_TWO, 32'h1);
    clr <= 1'b1;
    wait_n(1);
    clr <= 1'b0;
    wr(OFS_WAVE_CFG, 32'h37);
    rdc("restart bit clears", OFS_WAVE_CFG, 32'h36);
    wait_n(20);
    chk("restart level", 32'h100, {20'h0, last});
    rdc("status running", OFS_STATUS, 32'h1100);
    wait_n(5000);
    chk("square low", 32'h100, {20'h0, lo});
    chk("square high", 32'h700, {20'h0, hi});
    // four-tick slopes: ten ticks a period, first step lands after tick two
    wr(OFS_SLOPE_ONE, 32'h4);
    wr(OFS_SLOPE_TWO, 32'h4);
    wr(OFS_WAVE_CFG, 32'h37);
    wait_n(1550);
    chk("first slope step", 32'h280, {20'h0, last});
    n0 = hs_n;
    wait_n(5000);
    chk("period loads", 32'h9, hs_n - n0);
    chk("period end level", 32'h100, {20'h0, last});
    // disabled generator holds its code
    wr(OFS_FE_CTRL, 32'h0);
    wait_n(20);
    n0 = hs_n;
    wait_n(2000);
    chk("held loads", n0, hs_n);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk("run bit off", 32'h0, {31'h0, q[12]});
    wr(OFS_FE_CTRL, 32'h1);
    rdc("run bit on", OFS_FE_CTRL, 32'h1);
    // sine, full scale, top frequency
    wr(OFS_FREQ_WORD, 32'hFFFF_FFFF);
    rdc("freq word bits", OFS_FREQ_WORD, 32'h00FF_FFFF);
    wr(OFS_AMPLITUDE, 32'h7FF);
    wr(OFS_WAVE_CFG, 32'h34);
    wait_n(50);
    n0 = hs_n;
    wait_n(250);
    chk("sine update rate", 32'h1, {31'h0, (hs_n - n0) inside {[19:21]}});
    clr <= 1'b1;
    wait_n(1);
    clr <= 1'b0;
    wait_n(1000);
    chk("sine peak", 32'h1, {31'h0, hi > 12'hE00});
    chk("sine trough", 32'h1, {31'h0, lo < 12'h200});
    print_verdict();
  end
endmodule : tb_top

// [bench/wgen_dac_model.sv]
`timescale 1ns/100ps
module wgen_dac_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clr,
  input wire logic [11:0] hs_code,
  input wire logic hs_load,
  input wire logic [11:0] lp_code,
  input wire logic lp_load,
  output logic [31:0] hs_n,
  output logic [31:0] lp_n,
  output logic [11:0] last,
  output logic [11:0] lo,
  output logic [11:0] hi
);
  // ****************
  // converter inputs: latch a code only on its own load strobe
  // ****************
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hs_n <= 32'h0;
      lp_n <= 32'h0;
      last <= 12'h800;
      lo <= 12'hFFF;
      hi <= 12'h000;
    end else if (clr) begin
      lo <= 12'hFFF;
      hi <= 12'h000;
    end else if (hs_load || lp_load) begin
      hs_n <= hs_n + {31'h0, hs_load};
      lp_n <= lp_n + {31'h0, lp_load};
      last <= lp_load ? lp_code : hs_code;
      lo <= ((lp_load ? lp_code : hs_code) < lo) ? (lp_load ? lp_code : hs_code) : lo;
      hi <= ((lp_load ? lp_code : hs_code) > hi) ? (lp_load ? lp_code : hs_code) : hi;
    end
  end
endmodule : wgen_dac_model

// [hdl/wgen_pkg.sv]
package wgen_pkg;
  // ****************
  // register map
  // ****************
  localparam logic [15:0] OFS_FE_CTRL = 16'h2000;
  localparam logic [15:0] OFS_WAVE_CFG = 16'h2014;
  localparam logic [15:0] OFS_LEVEL_ONE = 16'h2018;
  localparam logic [15:0] OFS_LEVEL_TWO = 16'h201C;
  localparam logic [15:0] OFS_DELAY_ONE = 16'h2020;
  localparam logic [15:0] OFS_SLOPE_ONE = 16'h2024;
  localparam logic [15:0] OFS_DELAY_TWO = 16'h2028;
  localparam logic [15:0] OFS_SLOPE_TWO = 16'h202C;
  localparam logic [15:0] OFS_FREQ_WORD = 16'h2030;
  localparam logic [15:0] OFS_PHASE_OFS = 16'h2034;
  localparam logic [15:0] OFS_DC_OFS = 16'h2038;
  localparam logic [15:0] OFS_AMPLITUDE = 16'h203C;
  localparam logic [15:0] OFS_LP_CTRL = 16'h2040;
  localparam logic [15:0] OFS_FAST_CODE = 16'h2044;
  localparam logic [15:0] OFS_GAIN_CORR = 16'h2048;
  localparam logic [15:0] OFS_OFFSET_CORR = 16'h204C;
  localparam logic [15:0] OFS_STATUS = 16'h2050;
  // ****************
  // fields and reset values
  // ****************
  localparam int RUN_BIT = 0;
  localparam int RESTART_BIT = 0;
  localparam int TYPE_LSB = 1;
  localparam int OFS_CAL_BIT = 4;
  localparam int GAIN_CAL_BIT = 5;
  localparam int LP_SEL_BIT = 6;
  localparam int STATUS_RUN_BIT = 12;
  localparam logic [1:0] TYPE_DIRECT = 2'h0;
  localparam logic [1:0] TYPE_SINE = 2'h2;
  localparam logic [1:0] TYPE_TRAP = 2'h3;
  localparam logic CAL_RST = 1'b1;
  localparam logic [13:0] GAIN_RST = 14'h2000;
  localparam logic [11:0] DAC_MID = 12'h800;
  // ****************
  // timing
  // ****************
  localparam int CLK_HZ = 200_000_000;
  localparam int ACLK_HZ = 16_000_000;
  localparam int TRAP_TICK_HZ = 320_000;
  localparam int TRAP_TICK_CYC = CLK_HZ / TRAP_TICK_HZ;
  localparam int ACLK_NUM = ACLK_HZ / 1000;
  localparam int ACLK_DEN = CLK_HZ / 1000;
  localparam int ACC_W = 30;
  localparam int GAIN_FRAC = 13;
  localparam int AMP_FRAC = 11;
  typedef enum logic [1:0] {TRAP_DELAY1, TRAP_SLOPE1, TRAP_DELAY2, TRAP_SLOPE2} wgen_trap_t;
endpackage : wgen_pkg

// [hdl/wgen_sine.sv]
`timescale 1ns/100ps
module wgen_sine
  import wgen_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [5:0] phase,
  output logic signed [11:0] sine
);
  logic [10:0] mag;
  logic signed [11:0] next_sine;
  // quarter wave at half-step offsets so the mirror needs no extra entry
  function automatic logic [10:0] quarter(input logic [3:0] i);
    case (i)
      4'h0: quarter = 11'h064;
      4'h1: quarter = 11'h12C;
      4'h2: quarter = 11'h1F1;
      4'h3: quarter = 11'h2B2;
      4'h4: quarter = 11'h36B;
      4'h5: quarter = 11'h41C;
      4'h6: quarter = 11'h4C3;
      4'h7: quarter = 11'h55F;
      4'h8: quarter = 11'h5ED;
      4'h9: quarter = 11'h66C;
      4'hA: quarter = 11'h6DC;
      4'hB: quarter = 11'h73A;
      4'hC: quarter = 11'h787;
      4'hD: quarter = 11'h7C2;
      4'hE: quarter = 11'h7E9;
      default: quarter = 11'h7FD;
    endcase
  endfunction : quarter
  always_comb begin
    mag = quarter(phase[4] ? ~phase[3:0] : phase[3:0]);
    next_sine = phase[5] ? -$signed({1'b0, mag}) : $signed({1'b0, mag});
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sine <= '0;
    end else begin
      sine <= next_sine;
    end
  end
endmodule : wgen_sine

// [hdl/wgen_tick.sv]
`timescale 1ns/100ps
module wgen_tick
  import wgen_pkg::*;
#(
  parameter int NUM = 1,
  parameter int DEN = 2
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clear,
  output logic tick
);
  localparam int W = $clog2(DEN + NUM) + 1;
  logic [W-1:0] acc;
  logic [W-1:0] next_acc;
  logic [W-1:0] sum;
  logic next_tick;
  // fractional step keeps the long-run rate exact when DEN is no multiple of NUM
  always_comb begin
    sum = acc + W'(NUM);
    next_acc = sum;
    next_tick = 1'b0;
    if (clear) begin
      next_acc = '0;
    end else if (sum >= W'(DEN)) begin
      next_acc = sum - W'(DEN);
      next_tick = 1'b1;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc <= '0;
      tick <= 1'b0;
    end else begin
      acc <= next_acc;
      tick <= next_tick;
    end
  end
endmodule : wgen_tick

// [hdl/wgen_top.sv]
// Our own choice: register access over APB.
`timescale 1ns/100ps
module wgen_top
  import wgen_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [11:0] hs_dac_code,
  output logic hs_dac_load,
  output logic [11:0] lp_dac_code,
  output logic lp_dac_load
);
  logic run_en, lp_sel, gain_cal, ofs_cal;
  logic next_run, next_lp_sel, next_gain_cal, next_ofs_cal;
  logic [1:0] wave_type, next_type;
  logic [11:0] lvl_one, lvl_two, fast_code, dc_ofs, ofs_corr;
  logic [11:0] next_lvl_one, next_lvl_two, next_fast_code, next_dc_ofs, next_ofs_corr;
  logic [19:0] dly_one, dly_two, slp_one, slp_two, phase_ofs;
  logic [19:0] next_dly_one, next_dly_two, next_slp_one, next_slp_two, next_phase_ofs;
  logic [23:0] freq_word, next_freq_word;
  logic [10:0] amplitude, next_amplitude;
  logic [13:0] gain_corr, next_gain_corr;
  logic [31:0] rdata, next_prdata;
  logic wr, hit, cfg_wr, fe_wr, phase_load, trap_load, trap_go, aclk_tick, trap_tick;

  // ****************
  // apb slave
  // ****************
  assign wr = psel && penable && pwrite;
  assign cfg_wr = wr && paddr == OFS_WAVE_CFG;
  assign fe_wr = wr && paddr == OFS_FE_CTRL;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !hit;

  logic [11:0] out_code;
  always_comb begin
    rdata = '0;
    hit = 1'b1;
    case (paddr)
      OFS_FE_CTRL: rdata[RUN_BIT] = run_en;
      OFS_WAVE_CFG: begin
        rdata[GAIN_CAL_BIT] = gain_cal;
        rdata[OFS_CAL_BIT] = ofs_cal;
        rdata[TYPE_LSB +: 2] = wave_type;
      end
      OFS_LEVEL_ONE: rdata[11:0] = lvl_one;
      OFS_LEVEL_TWO: rdata[11:0] = lvl_two;
      OFS_DELAY_ONE: rdata[19:0] = dly_one;
      OFS_SLOPE_ONE: rdata[19:0] = slp_one;
      OFS_DELAY_TWO: rdata[19:0] = dly_two;
      OFS_SLOPE_TWO: rdata[19:0] = slp_two;
      OFS_FREQ_WORD: rdata[23:0] = freq_word;
      OFS_PHASE_OFS: rdata[19:0] = phase_ofs;
      OFS_DC_OFS: rdata[11:0] = dc_ofs;
      OFS_AMPLITUDE: rdata[10:0] = amplitude;
      OFS_LP_CTRL: rdata[LP_SEL_BIT] = lp_sel;
      OFS_FAST_CODE: rdata[11:0] = fast_code;
      OFS_GAIN_CORR: rdata[13:0] = gain_corr;
      OFS_OFFSET_CORR: rdata[11:0] = ofs_corr;
      OFS_STATUS: rdata[STATUS_RUN_BIT:0] = {run_en, out_code};
      default: hit = 1'b0;
    endcase
    // read data is caught in the setup cycle so the access phase needs no wait
    next_prdata = (psel && !penable && !pwrite) ? rdata : prdata;
  end

  always_comb begin
    next_run = run_en;
    next_type = wave_type;
    next_gain_cal = gain_cal;
    next_ofs_cal = ofs_cal;
    next_lp_sel = lp_sel;
    next_lvl_one = lvl_one;
    next_lvl_two = lvl_two;
    next_dly_one = dly_one;
    next_dly_two = dly_two;
    next_slp_one = slp_one;
    next_slp_two = slp_two;
    next_freq_word = freq_word;
    next_phase_ofs = phase_ofs;
    next_dc_ofs = dc_ofs;
    next_amplitude = amplitude;
    next_fast_code = fast_code;
    next_gain_corr = gain_corr;
    next_ofs_corr = ofs_corr;
    if (wr) begin
      case (paddr)
        OFS_FE_CTRL: next_run = pwdata[RUN_BIT];
        OFS_WAVE_CFG: begin
          next_type = pwdata[TYPE_LSB +: 2];
          next_gain_cal = pwdata[GAIN_CAL_BIT];
          next_ofs_cal = pwdata[OFS_CAL_BIT];
          if (pwdata[TYPE_LSB + 1]) next_run = 1'b1;
        end
        OFS_LEVEL_ONE: next_lvl_one = pwdata[11:0];
        OFS_LEVEL_TWO: next_lvl_two = pwdata[11:0];
        OFS_DELAY_ONE: next_dly_one = pwdata[19:0];
        OFS_SLOPE_ONE: next_slp_one = pwdata[19:0];
        OFS_DELAY_TWO: next_dly_two = pwdata[19:0];
        OFS_SLOPE_TWO: next_slp_two = pwdata[19:0];
        OFS_FREQ_WORD: next_freq_word = pwdata[23:0];
        OFS_PHASE_OFS: next_phase_ofs = pwdata[19:0];
        OFS_DC_OFS: next_dc_ofs = pwdata[11:0];
        OFS_AMPLITUDE: next_amplitude = pwdata[10:0];
        OFS_LP_CTRL: next_lp_sel = pwdata[LP_SEL_BIT];
        OFS_FAST_CODE: next_fast_code = pwdata[11:0];
        OFS_GAIN_CORR: next_gain_corr = pwdata[13:0];
        OFS_OFFSET_CORR: next_ofs_corr = pwdata[11:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
      run_en <= 1'b0;
      wave_type <= TYPE_DIRECT;
      gain_cal <= CAL_RST;
      ofs_cal <= CAL_RST;
      lp_sel <= 1'b0;
      {lvl_one, lvl_two, dc_ofs, fast_code, ofs_corr} <= '0;
      {dly_one, dly_two, slp_one, slp_two, phase_ofs} <= '0;
      freq_word <= '0;
      amplitude <= '0;
      gain_corr <= GAIN_RST;
    end else begin
      prdata <= next_prdata;
      run_en <= next_run;
      wave_type <= next_type;
      gain_cal <= next_gain_cal;
      ofs_cal <= next_ofs_cal;
      lp_sel <= next_lp_sel;
      {lvl_one, lvl_two, dc_ofs, fast_code, ofs_corr} <=
        {next_lvl_one, next_lvl_two, next_dc_ofs, next_fast_code, next_ofs_corr};
      {dly_one, dly_two, slp_one, slp_two, phase_ofs} <=
        {next_dly_one, next_dly_two, next_slp_one, next_slp_two, next_phase_ofs};
      freq_word <= next_freq_word;
      amplitude <= next_amplitude;
      gain_corr <= next_gain_corr;
    end
  end

  // a new type or a fresh enable restarts the source; same-type rewrites resume, and the restart bit restarts only the trapezoid source
  assign phase_load = (cfg_wr && next_type != wave_type) || (next_run && !run_en);
  assign trap_load = phase_load || (cfg_wr && pwdata[RESTART_BIT]);
  assign trap_go = run_en && wave_type == TYPE_TRAP;

  wgen_tick #(.NUM(ACLK_NUM), .DEN(ACLK_DEN)) u_aclk (
    .pclk(pclk), .presetn(presetn), .clear(phase_load), .tick(aclk_tick));
  wgen_tick #(.NUM(1), .DEN(TRAP_TICK_CYC)) u_trap_tick (
    .pclk(pclk), .presetn(presetn), .clear(trap_load), .tick(trap_tick));

  // ****************
  // sine source
  // ****************
  logic [ACC_W-1:0] acc, next_acc;
  logic signed [11:0] sine_val;
  logic signed [23:0] prod;
  logic [11:0] sine_code;
  wgen_sine u_sine (.pclk(pclk), .presetn(presetn), .phase(acc[ACC_W-1 -: 6]), .sine(sine_val));

  function automatic logic [11:0] clamp12(input logic signed [15:0] v);
    if (v < 16'sh0000) clamp12 = 12'h000;
    else if (v > 16'sh0FFF) clamp12 = 12'hFFF;
    else clamp12 = v[11:0];
  endfunction : clamp12

  always_comb begin
    next_acc = acc;
    if (phase_load) next_acc = {phase_ofs, 10'h000};
    else if (run_en && wave_type == TYPE_SINE && aclk_tick) next_acc = acc + {6'h00, freq_word};
    prod = sine_val * $signed({1'b0, amplitude});
    sine_code = clamp12($signed({4'h0, DAC_MID}) + 16'($signed(dc_ofs)) + 16'(prod >>> AMP_FRAC));
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) acc <= '0;
    else acc <= next_acc;
  end

  // ****************
  // trapezoid source
  // ****************
  wgen_trap_t trap_st, next_st;
  logic [19:0] trap_cnt, next_cnt, seg_len, step, div_den, next_den;
  logic [11:0] mag, div_q, next_q, div_base, next_base;
  logic [31:0] div_rem, next_rem;
  logic [32:0] shd;
  logic [3:0] div_bit, next_bit;
  logic div_busy, next_busy, div_up, next_up, seg_end;

  always_comb begin
    next_st = trap_st;
    next_cnt = trap_cnt;
    next_busy = div_busy;
    next_bit = div_bit;
    next_rem = div_rem;
    next_q = div_q;
    next_den = div_den;
    next_base = div_base;
    next_up = div_up;
    case (trap_st)
      TRAP_DELAY1: seg_len = dly_one;
      TRAP_SLOPE1: seg_len = slp_one;
      TRAP_DELAY2: seg_len = dly_two;
      default: seg_len = slp_two;
    endcase
    seg_end = {1'b0, trap_cnt} + 21'h1 >= {1'b0, seg_len};
    step = trap_cnt + 20'h1;
    mag = (lvl_two >= lvl_one) ? lvl_two - lvl_one : lvl_one - lvl_two;
    // long division: one quotient bit per clock, far inside one update tick
    shd = {13'h0, div_den} << div_bit;
    if (div_busy) begin
      if ({1'b0, div_rem} >= shd) begin
        next_rem = div_rem - shd[31:0];
        next_q[div_bit] = 1'b1;
      end
      next_bit = div_bit - 4'h1;
      if (div_bit == 4'h0) next_busy = 1'b0;
    end
    if (trap_load) begin
      next_st = TRAP_DELAY1;
      next_cnt = '0;
      next_busy = 1'b0;
    end else if (trap_go && trap_tick) begin
      if (trap_st == TRAP_SLOPE1 || trap_st == TRAP_SLOPE2) begin
        next_busy = 1'b1;
        next_bit = 4'hB;
        next_rem = {20'h0, mag} * {12'h0, step};
        next_q = '0;
        next_den = seg_len;
        next_up = (trap_st == TRAP_SLOPE1) == (lvl_two >= lvl_one);
        next_base = (trap_st == TRAP_SLOPE1) ? lvl_one : lvl_two;
      end
      if (seg_end) begin
        next_cnt = '0;
        case (trap_st)
          TRAP_DELAY1: next_st = (slp_one == 20'h0) ? TRAP_DELAY2 : TRAP_SLOPE1;
          TRAP_SLOPE1: next_st = TRAP_DELAY2;
          TRAP_DELAY2: next_st = (slp_two == 20'h0) ? TRAP_DELAY1 : TRAP_SLOPE2;
          TRAP_SLOPE2: next_st = TRAP_DELAY1;
          default: next_st = TRAP_DELAY1;
        endcase
      end else begin
        next_cnt = step;
      end
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trap_st <= TRAP_DELAY1;
      {trap_cnt, div_den} <= '0;
      {div_q, div_base} <= '0;
      div_rem <= '0;
      div_bit <= '0;
      {div_busy, div_up} <= '0;
    end else begin
      trap_st <= next_st;
      {trap_cnt, div_den} <= {next_cnt, next_den};
      {div_q, div_base} <= {next_q, next_base};
      div_rem <= next_rem;
      div_bit <= next_bit;
      {div_busy, div_up} <= {next_busy, next_up};
    end
  end

  // ****************
  // source select, correction, routing
  // ****************
  logic [11:0] raw, next_raw, next_out;
  logic raw_new, next_raw_new, next_hs_load, next_lp_load;
  logic signed [12:0] dev;
  logic signed [27:0] gprod;
  logic signed [15:0] adj;

  always_comb begin
    next_raw = raw;
    next_raw_new = 1'b1;
    // only direct-mode fast-code writes update while disabled, so otherwise the converter keeps its last code
    if (trap_load && next_type == TYPE_TRAP) next_raw = lvl_one;
    else if (wr && paddr == OFS_FAST_CODE && wave_type == TYPE_DIRECT) next_raw = pwdata[11:0];
    else if (run_en && wave_type == TYPE_SINE && aclk_tick) next_raw = sine_code;
    else if (trap_go && div_busy && div_bit == 4'h0) next_raw = div_up ? div_base + next_q : div_base - next_q;
    else if (trap_go && trap_tick && seg_end && next_st == TRAP_DELAY1) next_raw = lvl_one;
    else if (trap_go && trap_tick && seg_end && next_st == TRAP_DELAY2) next_raw = lvl_two;
    else next_raw_new = 1'b0;
    dev = $signed({1'b0, raw}) - $signed({1'b0, DAC_MID});
    gprod = dev * $signed({1'b0, gain_corr});
    adj = gain_cal ? 16'(gprod >>> GAIN_FRAC) : 16'(dev);
    adj = adj + $signed({4'h0, DAC_MID}) + (ofs_cal ? 16'($signed(ofs_corr)) : 16'sh0000);
    next_out = raw_new ? clamp12(adj) : out_code;
    next_hs_load = raw_new && !lp_sel;
    next_lp_load = raw_new && lp_sel;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      raw <= DAC_MID;
      raw_new <= 1'b0;
      out_code <= DAC_MID;
      hs_dac_load <= 1'b0;
      lp_dac_load <= 1'b0;
    end else begin
      raw <= next_raw;
      raw_new <= next_raw_new;
      out_code <= next_out;
      hs_dac_load <= next_hs_load;
      lp_dac_load <= next_lp_load;
    end
  end
  assign hs_dac_code = out_code;
  assign lp_dac_code = out_code;

  // ****************
  // assertions
  // ****************
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_type_sets_run;
    (cfg_wr && pwdata[TYPE_LSB + 1]) |=> run_en;
  endproperty
  a_type_sets_run: assert property (p_type_sets_run) else $error("type write left run off");
  property p_keeps_running;
    (run_en && !fe_wr) |=> run_en;
  endproperty
  a_keeps_running: assert property (p_keeps_running) else $error("run dropped by itself");
  property p_hold_off;
    (!run_en && wave_type != TYPE_DIRECT && !wr) |=> !raw_new ##1 $stable(out_code);
  endproperty
  a_hold_off: assert property (p_hold_off) else $error("code moved while off");
  property p_phase_step;
    (aclk_tick && run_en && wave_type == TYPE_SINE && !phase_load)
      |=> acc == $past(acc) + {6'h00, $past(freq_word)};
  endproperty
  a_phase_step: assert property (p_phase_step) else $error("bad phase step");
  property p_phase_still;
    (!aclk_tick && !phase_load) |=> $stable(acc);
  endproperty
  a_phase_still: assert property (p_phase_still) else $error("phase moved off tick");
  property p_phase_load;
    (cfg_wr && pwdata[2:1] == TYPE_SINE && wave_type != TYPE_SINE) |=> acc == {phase_ofs, 10'h000};
  endproperty
  a_phase_load: assert property (p_phase_load) else $error("phase not preloaded");
  property p_restart;
    (cfg_wr && pwdata[RESTART_BIT] && pwdata[2:1] == TYPE_TRAP)
      |=> trap_st == TRAP_DELAY1 && trap_cnt == 20'h0 && raw == lvl_one && raw_new;
  endproperty
  a_restart: assert property (p_restart) else $error("restart missed");
  property p_tick_only;
    (!trap_tick && !trap_load) |=> $stable(trap_st) && $stable(trap_cnt);
  endproperty
  a_tick_only: assert property (p_tick_only) else $error("trap moved off tick");
  property p_square;
    (trap_go && trap_tick && trap_st == TRAP_DELAY1 && seg_end && slp_one == 20'h0 && !trap_load)
      |=> trap_st == TRAP_DELAY2 && raw == lvl_two;
  endproperty
  a_square: assert property (p_square) else $error("zero slope did not jump");
  property p_period;
    (trap_go && trap_tick && trap_st == TRAP_SLOPE2 && seg_end && !trap_load)
      |=> trap_st == TRAP_DELAY1 && raw == lvl_one;
  endproperty
  a_period: assert property (p_period) else $error("period did not wrap");
  property p_route;
    raw_new |=> lp_dac_load == $past(lp_sel) && hs_dac_load == !$past(lp_sel);
  endproperty
  a_route: assert property (p_route) else $error("wrong converter loaded");
  property p_bypass;
    (raw_new && !gain_cal && !ofs_cal) |=> out_code == $past(raw);
  endproperty
  a_bypass: assert property (p_bypass) else $error("bypass altered code");
  c_sine_run: cover property (run_en && wave_type == TYPE_SINE && aclk_tick);
  c_slope_two: cover property (trap_go && trap_st == TRAP_SLOPE2 && trap_tick);
  c_lp_load: cover property (lp_dac_load);
endmodule : wgen_top
